// file: logic/hwtfu_pkg.sv
// Purpose: Shared constants for the hardware table flag update engine
// Assumes: 64-bit descriptors, 32-bit register port
// Notes: Bit positions are parameters so another descriptor format can be used
`default_nettype none
package hwtfu_pkg;
    // Descriptor field positions
    localparam int unsigned AF_BIT = 10;         // Access flag
    localparam int unsigned S1_AP2_BIT = 7;      // Stage 1 upper permission bit, set = read-only
    localparam int unsigned S2_AP1_BIT = 7;      // Stage 2 write bit, set = writable
    localparam int unsigned DBM_BIT = 51;        // Dirty modifier bit
    localparam int unsigned DESC_W = 64;         // Descriptor width

    // Register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;     // Control
    localparam logic [7:0] REG_STATUS = 8'h04;   // Status
    localparam logic [7:0] REG_AF_CNT = 8'h08;   // Access flag updates done
    localparam logic [7:0] REG_DIRTY_CNT = 8'h0C;// Dirty updates done
    localparam logic [7:0] REG_RETRY_CNT = 8'h10;// Compare-and-swap retries
    localparam logic [7:0] REG_FAULT_CNT = 8'h14;// Faults reported

    // Control register fields
    localparam int unsigned CTRL_AF_EN = 0;      // Access flag update implemented and on
    localparam int unsigned CTRL_DIRTY_EN = 1;   // Dirty update implemented and on
    localparam int unsigned CTRL_W = 2;          // Control width
    localparam logic [1:0] CTRL_RESET = 2'h0;    // Both off after reset

    // Status register fields
    localparam int unsigned STAT_BUSY = 0;       // Engine working
    localparam int unsigned STAT_SYNC = 1;       // Sync waiting

    // Counter width
    localparam int unsigned CNT_W = 16;
endpackage
`default_nettype wire

// file: logic/hwtfu_engine.sv
// Purpose: Sets access flags and marks writable-clean descriptors dirty during a walk
// Assumes: Walker hands one descriptor at a time; memory offers compare-and-swap
// Notes: Sync and invalidate completion wait until no swap is in flight
`timescale 1ns/1ps
`default_nettype none
module hwtfu_engine #(
    parameter int unsigned ADDR_W = 48   // Descriptor address width
) (
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Walker request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [hwtfu_pkg::DESC_W-1:0] req_desc,
    input wire logic req_stage2,          // Descriptor belongs to stage 2
    input wire logic req_table,           // Table descriptor, not block or page
    input wire logic req_write,           // Translation is for a write
    input wire logic req_ctx_fetch,       // Stage 2 walk for a context descriptor fetch
    input wire logic req_indirect,        // Stage uses the indirect permission scheme
    input wire logic req_ind_clean,       // Indirect scheme says writable-clean
    input wire logic req_af_hw_en,        // Stream enables access flag update for stage
    input wire logic req_dirty_hw_en,     // Stream or context enables dirty update for stage
    input wire logic req_table_af_en,     // Table flag update enable for stage
    input wire logic req_af_fault_dis,    // Access fault disable for stage
    input wire logic req_table_limit_ro,  // Table-level limit removed write
    input wire logic req_other_perm_fault,// Permission fault for any other reason
    input wire logic req_s2_write_ok,     // Stage 2 mapping of a stage 1 descriptor permits writes
    // Walker result
    output logic res_valid,
    output logic res_ok,
    output logic res_access_fault,
    output logic res_perm_fault,
    output logic res_tlb_cacheable,
    output logic [hwtfu_pkg::DESC_W-1:0] res_desc,
    // Coherent memory compare-and-swap
    output logic cas_req,
    output logic [ADDR_W-1:0] cas_addr,
    output logic [hwtfu_pkg::DESC_W-1:0] cas_compare,
    output logic [hwtfu_pkg::DESC_W-1:0] cas_swap,
    input wire logic cas_ack,
    input wire logic [hwtfu_pkg::DESC_W-1:0] cas_old,
    // Ordering commands
    input wire logic sync_req,            // Sync command or invalidation reaches completion
    output logic sync_done
);
    localparam int unsigned DW = hwtfu_pkg::DESC_W;
    localparam int unsigned CW = hwtfu_pkg::CNT_W;

    ////////////////////////////////////////////////////////////////////////////
    // State

    // One-hot engine states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,   // Waiting for walker
        ST_EVAL = 4'h2,   // Decide update and faults
        ST_CAS = 4'h4,    // Swap outstanding in memory
        ST_DONE = 4'h8    // Result shown for one cycle
    } hwtfu_state_e;

    // All registered state of the engine
    typedef struct packed {
        hwtfu_state_e st;
        logic [ADDR_W-1:0] addr;     // Descriptor address
        logic [DW-1:0] desc;         // Current view of memory
        logic [DW-1:0] upd;          // Value being swapped in
        logic [12:0] fl;             // Latched request flags
        logic ready;
        logic rvalid;
        logic rok;
        logic raf;
        logic rpf;
        logic rcache;
        logic cas;
        logic sync_pend;
        logic sync_ack;
        logic [hwtfu_pkg::CTRL_W-1:0] ctrl;
        logic [CW-1:0] cnt_af;
        logic [CW-1:0] cnt_dirty;
        logic [CW-1:0] cnt_retry;
        logic [CW-1:0] cnt_fault;
        logic [31:0] rdata;
    } hwtfu_state_s;

    hwtfu_state_s s_q;
    hwtfu_state_s s_d;

    // Flag positions inside the latched vector
    localparam int unsigned F_S2 = 0;
    localparam int unsigned F_TBL = 1;
    localparam int unsigned F_WR = 2;
    localparam int unsigned F_CTX = 3;
    localparam int unsigned F_IND = 4;
    localparam int unsigned F_ICLN = 5;
    localparam int unsigned F_AFEN = 6;
    localparam int unsigned F_DEN = 7;
    localparam int unsigned F_TAFEN = 8;
    localparam int unsigned F_ACCESS_FAULT_DISABLE = 9;
    localparam int unsigned F_TLRO = 10;
    localparam int unsigned F_OPF = 11;
    localparam int unsigned F_S2WR = 12;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    // Evaluation terms, all from registered state
    logic af_on;        // Access flag update allowed here
    logic dirty_on;     // Dirty update allowed by enables
    logic af_clr;       // Descriptor access flag clear
    logic writable;     // Already writable-dirty
    logic clean_ok;     // Eligible for dirty marking
    logic afault;       // Access fault to report
    logic pfault;       // Permission fault to report
    logic do_af;        // Set the access flag
    logic do_dirty;     // Mark dirty
    logic [DW-1:0] nval;// Value to swap in

    // Decide faults and the new descriptor value
    always_comb begin
        // Update only when implemented, on, and enabled for the stream
        af_on = s_q.ctrl[hwtfu_pkg::CTRL_AF_EN] && s_q.fl[F_AFEN];
        // Table flag update needs its own enable and the flag update itself
        if (s_q.fl[F_TBL]) begin
            af_on = af_on && s_q.fl[F_TAFEN];
        end
        // Either scheme: the control bit and the stage enable decide
        dirty_on = s_q.ctrl[hwtfu_pkg::CTRL_DIRTY_EN] && s_q.fl[F_DEN];
        af_clr = !s_q.desc[hwtfu_pkg::AF_BIT];
        writable = s_q.fl[F_S2] ? s_q.desc[hwtfu_pkg::S2_AP1_BIT] : !s_q.desc[hwtfu_pkg::S1_AP2_BIT];
        // Modifier bit is only meaningful under the direct scheme
        if (s_q.fl[F_IND]) begin
            clean_ok = s_q.fl[F_ICLN];
        end else begin
            clean_ok = s_q.desc[hwtfu_pkg::DBM_BIT];
        end
        // Table limit and context fetch stage 2 never get write granted
        clean_ok = clean_ok && !s_q.fl[F_TLRO] && !(s_q.fl[F_S2] && s_q.fl[F_CTX]);
        // Access fault outranks a permission fault
        afault = af_clr && !s_q.fl[F_ACCESS_FAULT_DISABLE] && !af_on;
        pfault = 1'b0;
        do_dirty = 1'b0;
        if (!afault) begin
            if (s_q.fl[F_OPF]) begin
                pfault = 1'b1;
            end else if (s_q.fl[F_WR] && !s_q.fl[F_TBL] && !writable) begin
                // Writable-dirty never reaches here
                if (dirty_on && clean_ok) begin
                    do_dirty = 1'b1;
                end else begin
                    pfault = 1'b1;
                end
            end
        end
        // Flag set only, left alone under a permission fault
        do_af = af_on && af_clr && !afault && !pfault;
        // Dirty marking carries the access flag with it
        if (do_dirty) begin
            do_af = af_clr;
        end
        // Stage 1 update is itself a write checked by stage 2
        if ((do_af || do_dirty) && !s_q.fl[F_S2] && !s_q.fl[F_S2WR]) begin
            pfault = 1'b1;
            do_af = 1'b0;
            do_dirty = 1'b0;
        end
        // Only the two flag bits may move, and only one way
        nval = s_q.desc;
        if (do_af) begin
            nval[hwtfu_pkg::AF_BIT] = 1'b1;
        end
        if (do_dirty) begin
            if (s_q.fl[F_S2]) begin
                nval[hwtfu_pkg::S2_AP1_BIT] = 1'b1;
            end else begin
                nval[hwtfu_pkg::S1_AP2_BIT] = 1'b0;
            end
        end
    end

    // Sequencer, register port and ordering
    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        s_d.sync_ack = 1'b0;
        case (s_q.st)
            ST_IDLE: begin
                // Accept one descriptor
                if (req_valid) begin
                    s_d.st = ST_EVAL;
                    s_d.ready = 1'b0;
                    s_d.addr = req_addr;
                    s_d.desc = req_desc;
                    s_d.fl = {req_s2_write_ok, req_other_perm_fault, req_table_limit_ro, req_af_fault_dis,
                              req_table_af_en, req_dirty_hw_en, req_af_hw_en, req_ind_clean,
                              req_indirect, req_ctx_fetch, req_write, req_table, req_stage2};
                end
            end
            ST_EVAL: begin
                if (!afault && !pfault && (do_af || do_dirty)) begin
                    // Swap against the value seen, never a blind write
                    s_d.st = ST_CAS;
                    s_d.upd = nval;
                    s_d.cas = 1'b1;
                end else begin
                    s_d.st = ST_DONE;
                    s_d.rvalid = 1'b1;
                    s_d.rok = !afault && !pfault;
                    s_d.raf = afault;
                    s_d.rpf = pfault;
                    // Table entry with flag clear and table flag update enabled stays out of the TLB
                    s_d.rcache = !(s_q.fl[F_TBL] && s_q.fl[F_TAFEN] && af_clr);
                    if (afault || pfault) begin
                        s_d.cnt_fault = s_q.cnt_fault + CW'(1);
                    end
                end
            end
            ST_CAS: begin
                s_d.cas = 1'b0;
                if (cas_ack) begin
                    if (cas_old == s_q.desc) begin
                        // Swap took; result carries the new value
                        s_d.st = ST_DONE;
                        s_d.desc = s_q.upd;
                        s_d.rvalid = 1'b1;
                        s_d.rok = 1'b1;
                        s_d.raf = 1'b0;
                        s_d.rpf = 1'b0;
                        s_d.rcache = 1'b1;
                        if (s_q.upd[hwtfu_pkg::AF_BIT] != s_q.desc[hwtfu_pkg::AF_BIT]) begin
                            s_d.cnt_af = s_q.cnt_af + CW'(1);
                        end
                        if (s_q.upd != s_q.desc && s_q.upd[hwtfu_pkg::AF_BIT] == s_q.desc[hwtfu_pkg::AF_BIT]) begin
                            s_d.cnt_dirty = s_q.cnt_dirty + CW'(1);
                        end else if (s_q.upd[hwtfu_pkg::S1_AP2_BIT] != s_q.desc[hwtfu_pkg::S1_AP2_BIT]) begin
                            s_d.cnt_dirty = s_q.cnt_dirty + CW'(1);
                        end
                    end else begin
                        // Someone else changed it: decide again on fresh value
                        s_d.st = ST_EVAL;
                        s_d.desc = cas_old;
                        s_d.cnt_retry = s_q.cnt_retry + CW'(1);
                    end
                end
            end
            ST_DONE: begin
                s_d.st = ST_IDLE;
                s_d.ready = 1'b1;
            end
            default: begin
                s_d.st = ST_IDLE;
                s_d.ready = 1'b1;
                s_d.cas = 1'b0;
            end
        endcase
        // Sync or invalidation completes only with no swap in flight;
        // a simple global wait trades a little latency for no tracking
        if (s_q.sync_pend && s_q.st != ST_CAS) begin
            s_d.sync_pend = 1'b0;
            s_d.sync_ack = 1'b1;
        end
        // A new request wins over the clear
        if (sync_req) begin
            s_d.sync_pend = 1'b1;
        end
        // Register write
        if (reg_wr && reg_addr == hwtfu_pkg::REG_CTRL) begin
            s_d.ctrl = reg_wdata[hwtfu_pkg::CTRL_W-1:0];
        end
        // Register read, data in the next cycle; unmapped reads zero
        s_d.rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                hwtfu_pkg::REG_CTRL: s_d.rdata = {{(32-hwtfu_pkg::CTRL_W){1'b0}}, s_q.ctrl};
                hwtfu_pkg::REG_STATUS: begin
                    s_d.rdata[hwtfu_pkg::STAT_BUSY] = !s_q.ready;
                    s_d.rdata[hwtfu_pkg::STAT_SYNC] = s_q.sync_pend;
                end
                hwtfu_pkg::REG_AF_CNT: s_d.rdata = {{(32-CW){1'b0}}, s_q.cnt_af};
                hwtfu_pkg::REG_DIRTY_CNT: s_d.rdata = {{(32-CW){1'b0}}, s_q.cnt_dirty};
                hwtfu_pkg::REG_RETRY_CNT: s_d.rdata = {{(32-CW){1'b0}}, s_q.cnt_retry};
                hwtfu_pkg::REG_FAULT_CNT: s_d.rdata = {{(32-CW){1'b0}}, s_q.cnt_fault};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Whole state in one flop bank
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.ready <= 1'b1;
            s_q.ctrl <= hwtfu_pkg::CTRL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, straight from flops

    assign req_ready = s_q.ready;
    assign res_valid = s_q.rvalid;
    assign res_ok = s_q.rok;
    assign res_access_fault = s_q.raf;
    assign res_perm_fault = s_q.rpf;
    assign res_tlb_cacheable = s_q.rcache;
    assign res_desc = s_q.desc;
    assign cas_req = s_q.cas;
    assign cas_addr = s_q.addr;
    assign cas_compare = s_q.desc;
    assign cas_swap = s_q.upd;
    assign sync_done = s_q.sync_ack;
    assign reg_rdata = s_q.rdata;

endmodule // hwtfu_engine
`default_nettype wire

// file: tb/hwtfu_engine_assertions.sv
// Purpose: Port-level checks of the flag update engine
// Assumes: Only the engine's own ports are visible
// Notes: Helper flags remember stage and swap state between cycles
`timescale 1ns/1ps
`default_nettype none
module hwtfu_engine_assertions (
    input wire logic clk,
    input wire logic resetn,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [hwtfu_pkg::DESC_W-1:0] req_desc,
    input wire logic req_stage2,
    input wire logic req_table,
    input wire logic req_ctx_fetch,
    input wire logic req_af_hw_en,
    input wire logic req_af_fault_dis,
    input wire logic req_other_perm_fault,
    input wire logic res_valid,
    input wire logic res_access_fault,
    input wire logic cas_req,
    input wire logic [hwtfu_pkg::DESC_W-1:0] cas_compare,
    input wire logic [hwtfu_pkg::DESC_W-1:0] cas_swap,
    input wire logic cas_ack,
    input wire logic sync_req,
    input wire logic sync_done
);
    localparam int unsigned F = hwtfu_pkg::AF_BIT; // Flag position
    localparam int unsigned W = hwtfu_pkg::S1_AP2_BIT; // Write control, both stages
    localparam int unsigned M = hwtfu_pkg::DBM_BIT; // Modifier position
    logic s2_q; // Stage of the walk in flight
    logic cx_q; // Walk is a context fetch
    logic busy_q; // Swap outstanding
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Remember what the swap belongs to; swap fields alone do not say
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s2_q <= 1'b0;
            cx_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            if (req_valid && req_ready) begin
                s2_q <= req_stage2;
                cx_q <= req_ctx_fetch;
            end
            if (cas_req) begin
                busy_q <= 1'b1;
            end else if (cas_ack) begin
                busy_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access fault when no update may help
    property p_fault;
        req_valid && req_ready && !req_af_hw_en && !req_table && !req_af_fault_dis && !req_other_perm_fault
            && !req_desc[F] |-> ##2 res_valid && res_access_fault;
    endproperty
    flag_keep_a: assert property (cas_req |-> !(cas_compare[F] && !cas_swap[F]))
        else $error("swap clears access flag");
    mod_keep_a: assert property (cas_req |-> cas_swap[M] == cas_compare[M])
        else $error("swap changes modifier bit");
    s2_write_keep_a: assert property (cas_req && s2_q |-> !(cas_compare[W] && !cas_swap[W]))
        else $error("swap revokes stage 2 write");
    s1_ro_keep_a: assert property (cas_req && !s2_q |-> !(!cas_compare[W] && cas_swap[W]))
        else $error("swap makes stage 1 read-only");
    dirty_flag_a: assert property (cas_req && (cas_compare[W] != cas_swap[W]) |-> cas_swap[F])
        else $error("dirty swap without access flag");
    ctx_no_grant_a: assert property (cas_req && s2_q && cx_q |-> cas_compare[W] == cas_swap[W])
        else $error("context fetch made writable");
    walk_timing_a: assert property (req_valid && req_ready |=> !req_ready ##1 (res_valid || cas_req))
        else $error("walk answer late");
    swap_hold_a: assert property (busy_q && !cas_ack |=> $stable(cas_swap) && $stable(cas_compare))
        else $error("swap changed before ack");
    fault_raise_a: assert property (p_fault)
        else $error("missing access fault");
    sync_prompt_a: assert property (sync_req && req_ready && !cas_req && !busy_q |-> ##2 sync_done)
        else $error("idle sync not completed");
    swap_seen_c: cover property (cas_req);
    fault_seen_c: cover property (res_valid && res_access_fault);
    sync_wait_c: cover property (sync_req && busy_q);
endmodule // hwtfu_engine_assertions
bind hwtfu_engine hwtfu_engine_assertions u_chk (.*);
`default_nettype wire

// file: tb/hwtfu_mem_model.sv
// Purpose: Coherent memory holding one descriptor, answers compare-and-swap
// Assumes: One swap in flight at a time
// Notes: Old value is only shown with the ack; elsewhere its inverse
`timescale 1ns/1ps
`default_nettype none
module hwtfu_mem_model (
    input wire logic clk,
    input wire logic cas_req,
    input wire logic [63:0] cas_compare,
    input wire logic [63:0] cas_swap,
    output logic cas_ack,
    output logic [63:0] cas_old,
    input wire logic [3:0] delay,
    input wire logic load,
    input wire logic [63:0] load_val,
    output logic [63:0] mem
);
    int n = -1; // Cycles to ack, -1 idle
    initial cas_ack = 1'b0;

    // Swap lands at the ack edge, so a slow ack stalls the engine
    always @(posedge clk) begin
        cas_ack <= 1'b0;
        cas_old <= ~mem;
        if (load) begin
            mem <= load_val;
        end
        if (cas_req && n < 0) begin
            n <= int'(delay);
        end else if (n > 0) begin
            n <= n - 1;
        end else if (n == 0) begin
            cas_ack <= 1'b1;
            cas_old <= mem;
            n <= -1;
            if (mem == cas_compare) begin
                mem <= cas_swap;
            end
        end
    end
endmodule // hwtfu_mem_model
`default_nettype wire

// file: tb/tb.sv
// Purpose: Self-checking bench for the flag update engine
// Assumes: Memory model answers every swap
// Notes: Walk flags are packed in f, see the F_ masks
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(64'(g), 64'(e))
module tb;
    localparam logic [63:0] B = 64'h0000_0000_8765_4003; // Plain descriptor
    localparam logic [63:0] M_FLAG = 64'h1 << hwtfu_pkg::AF_BIT;
    localparam logic [63:0] M_PERM = 64'h1 << hwtfu_pkg::S1_AP2_BIT;
    localparam logic [63:0] M_S2W = 64'h1 << hwtfu_pkg::S2_AP1_BIT;
    localparam logic [63:0] M_MOD = 64'h1 << hwtfu_pkg::DBM_BIT;
    localparam logic [12:0] F_S2 = 13'h1000, F_TBL = 13'h0800, F_WR = 13'h0400, F_CX = 13'h0200;
    localparam logic [12:0] F_IND = 13'h0100, F_IC = 13'h0080, F_AH = 13'h0040, F_DH = 13'h0020;
    localparam logic [12:0] F_TA = 13'h0010, F_FD = 13'h0008, F_LR = 13'h0004, F_OP = 13'h0002, F_SW = 13'h0001;
    localparam logic [12:0] H = 13'h0061; // Both updates on, stage 2 permits
    localparam logic [2:0] OK = 3'h4, AFT = 3'h2, PFT = 3'h1; // ok, access, permission
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0, sync_req = 1'b0, load = 1'b0;
    logic [47:0] req_addr = 48'h0, cas_addr;
    logic [63:0] req_desc = 64'h0, load_val = 64'h0, skew = 64'h0, res_desc, cas_compare, cas_swap, cas_old, mem;
    logic [12:0] f = 13'h0; // Walk flags
    logic [3:0] delay = 4'h0; // Memory ack delay
    logic req_stage2, req_table, req_write, req_ctx_fetch, req_indirect, req_ind_clean, req_af_hw_en;
    logic req_dirty_hw_en, req_table_af_en, req_af_fault_dis, req_table_limit_ro, req_other_perm_fault;
    logic req_s2_write_ok, req_ready, res_valid, res_ok, res_access_fault, res_perm_fault;
    logic res_tlb_cacheable, cas_req, cas_ack, sync_done;
    int n_mismatch = 0, tests_run = 0, j;
    assign {req_stage2, req_table, req_write, req_ctx_fetch, req_indirect, req_ind_clean, req_af_hw_en,
            req_dirty_hw_en, req_table_af_en, req_af_fault_dis, req_table_limit_ro, req_other_perm_fault,
            req_s2_write_ok} = f;
    hwtfu_engine u_dut (.*);
    hwtfu_mem_model u_mem (.*);

    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        `CHK(reg_rdata, e);
    endtask
    // One walk; memory holds d^skew, so a skew forces a failed swap
    task automatic walk(input logic [63:0] d, input logic [12:0] fl, input logic [2:0] er, input logic [63:0] em);
        int k;
        @(posedge clk);
        load <= 1'b1;
        load_val <= d ^ skew;
        req_desc <= d;
        f <= fl;
        req_valid <= 1'b1;
        k = 0;
        @(negedge clk);
        while (req_ready !== 1'b1 && k < 40) begin
            @(negedge clk);
            k++;
        end
        @(posedge clk);
        load <= 1'b0;
        req_valid <= 1'b0;
        k = 0;
        @(negedge clk);
        while (res_valid !== 1'b1 && k < 40) begin
            @(negedge clk);
            k++;
        end
        `CHK(res_valid, 1'b1);
        `CHK({res_ok, res_access_fault, res_perm_fault}, er);
        `CHK(res_desc, em);
        `CHK(mem, em);
        @(posedge clk);
        @(posedge clk);
        $display("walk done at %0t", $time);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        close_out();
    end

    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        rchk(hwtfu_pkg::REG_CTRL, 32'h0);
        rchk(hwtfu_pkg::REG_STATUS, 32'h0);
        rchk(8'h20, 32'h0);
        wreg(hwtfu_pkg::REG_AF_CNT, 32'hFFFF);
        rchk(hwtfu_pkg::REG_AF_CNT, 32'h0);
        wreg(hwtfu_pkg::REG_CTRL, 32'h3);
        rchk(hwtfu_pkg::REG_CTRL, 32'h3);
        $display("register test done");
        delay <= 4'h2;
        skew <= M_FLAG | 64'h0000_0000_0010_0000;
        walk(B, H, OK, B ^ M_FLAG ^ 64'h0000_0000_0010_0000);
        skew <= 64'h0;
        rchk(hwtfu_pkg::REG_RETRY_CNT, 32'h1);
        walk(B, H, OK, B | M_FLAG);
        walk(B, H | F_S2 | F_CX, OK, B | M_FLAG);
        walk(B | M_MOD | M_PERM, H | F_WR, OK, B | M_MOD | M_FLAG);
        walk(B | M_MOD, H | F_WR | F_S2, OK, B | M_MOD | M_FLAG | M_S2W);
        walk(B | M_FLAG | M_PERM, H | F_WR, PFT, B | M_FLAG | M_PERM);
        walk(B | M_FLAG | M_MOD | M_PERM, H | F_WR | F_LR, PFT, B | M_FLAG | M_MOD | M_PERM);
        walk(B | M_FLAG | M_MOD, H | F_WR | F_S2 | F_CX, PFT, B | M_FLAG | M_MOD);
        walk(B | M_FLAG | M_MOD | M_PERM, F_AH | F_DH | F_WR, PFT, B | M_FLAG | M_MOD | M_PERM);
        walk(B | M_FLAG | M_PERM, H | F_WR | F_IND | F_IC, OK, B | M_FLAG);
        walk(B, F_TBL | F_AH | F_TA | F_SW, OK, B | M_FLAG);
        @(negedge clk) `CHK(res_tlb_cacheable, 1'b1);
        walk(B, F_DH | F_SW, AFT, B);
        wreg(hwtfu_pkg::REG_CTRL, 32'h0);
        walk(B | M_FLAG, F_WR, OK, B | M_FLAG);
        walk(B, H, AFT, B);
        walk(B, F_FD, OK, B);
        // Table entry with flag clear and no update must stay out of the TLB
        walk(B, F_TBL | F_TA | F_FD, OK, B);
        @(negedge clk) `CHK(res_tlb_cacheable, 1'b0);
        wreg(hwtfu_pkg::REG_CTRL, 32'h3);
        walk(B, H | F_OP, PFT, B);
        @(posedge clk);
        sync_req <= 1'b1;
        @(posedge clk);
        sync_req <= 1'b0;
        // Pending flag was set at the last edge; at this edge it clears and the done pulse rises
        @(posedge clk);
        @(negedge clk);
        `CHK(sync_done, 1'b1);
        delay <= 4'h6;
        // A sync issued during a slow swap must wait for it
        fork
            walk(B, H, OK, B | M_FLAG);
            begin
                wait (cas_req === 1'b1);
                @(posedge clk);
                sync_req <= 1'b1;
                @(posedge clk);
                sync_req <= 1'b0;
                @(negedge clk);
                `CHK(sync_done, 1'b0);
                j = 0;
                while (sync_done !== 1'b1 && j < 20) begin
                    @(negedge clk);
                    j++;
                end
                `CHK(sync_done, 1'b1);
            end
        join
        $display("sync test done");
        rchk(hwtfu_pkg::REG_AF_CNT, 32'h6);
        rchk(hwtfu_pkg::REG_DIRTY_CNT, 32'h3);
        rchk(hwtfu_pkg::REG_FAULT_CNT, 32'h7);
        close_out();
    end
endmodule // tb
`default_nettype wire
